// ### verilog/adcts_pkg.sv
`default_nettype none
package adcts_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  localparam int TRIG_N = 6;
  localparam int MAP_N = 6;
  localparam int IRQ_N = 4;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MAP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PUMP = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h20;

  // Control and result register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_DIFF_BIT = 8;
  localparam int CTRL_CHAN_LSB = 16;
  localparam int RESULT_BUSY_BIT = 16;

  // Map register fields, one bit per input 26..31.
  localparam int MAP_CH3_BIT = 0;
  localparam int MAP_CH2_BIT = 1;
  localparam int MAP_CH1_BIT = 2;
  localparam int MAP_CH0_BIT = 3;
  localparam int MAP_TEMP_BIT = 4;
  localparam int MAP_BATT_BIT = 5;

  // Status, enable and clear layout.
  localparam int IRQ_ABOVE_BIT = 0;
  localparam int IRQ_BELOW_BIT = 1;
  localparam int IRQ_INSIDE_BIT = 2;
  localparam int IRQ_DONE_BIT = 3;

  // Reset values.
  localparam logic [2:0] RST_TRIG = 3'h0;
  localparam logic [4:0] RST_CHAN = 5'h00;
  localparam logic [MAP_N-1:0] RST_MAP = 6'h00;
  localparam logic [7:0] RST_PUMP = 8'h00;
  localparam logic [RES_W-1:0] RST_LOW = 12'h000;
  localparam logic [RES_W-1:0] RST_HIGH = 12'hFFF;

  // Trigger source codes.
  localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] TRIG_RESERVED = 3'h7;

  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SAMPLE_TIME_NS = 20;
  localparam int BIT_TIME_NS = 20;
  localparam int SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcts_state_e;
endpackage
`default_nettype wire

// ### verilog/adcts_window.sv
`timescale 1ns/1ps
`default_nettype none
module adcts_window (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic [adcts_pkg::RES_W-1:0] result_i,
  input wire logic [adcts_pkg::RES_W-1:0] low_i,
  input wire logic [adcts_pkg::RES_W-1:0] high_i,
  output logic above_o,
  output logic below_o,
  output logic inside_o
);
  import adcts_pkg::*;

  logic next_above;
  logic next_below;
  logic next_inside;

  // Each finished result raises exactly one pulse when the limits are ordered.
  always_comb begin
    next_above = valid_i && (result_i > high_i);
    next_below = valid_i && (result_i < low_i);
    next_inside = valid_i && (result_i >= low_i) && (result_i <= high_i);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      above_o <= 1'b0;
      below_o <= 1'b0;
      inside_o <= 1'b0;
    end else begin
      above_o <= next_above;
      below_o <= next_below;
      inside_o <= next_inside;
    end
  end
endmodule
`default_nettype wire

// ### verilog/adcts_top.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adcts_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [adcts_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [adcts_pkg::DATA_W-1:0] pwdata_i,
  output logic [adcts_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [adcts_pkg::TRIG_N-1:0] timer_cmp_i,
  input wire logic comp_i,
  output logic [adcts_pkg::RES_W-1:0] dac_code_o,
  output logic sample_o,
  output logic ref_en_o,
  output logic diff_mode_o,
  output logic [4:0] chan_sel_o,
  output logic [adcts_pkg::MAP_N-1:0] pin_switch_o,
  output logic batt_route_o,
  output logic temp_route_o,
  output logic pump_off_o,
  output logic irq_o
);
  import adcts_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and timer edge detection.

  logic comp_meta;
  logic comp_sync;
  logic [TRIG_N-1:0] cmp_q;
  logic [TRIG_N-1:0] cmp_rise;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      cmp_q <= '0;
    end else begin
      comp_meta <= comp_i;
      comp_sync <= comp_meta;
      cmp_q <= timer_cmp_i;
    end
  end

  assign cmp_rise = timer_cmp_i & ~cmp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and APB slave.

  logic enable;
  logic diff_mode;
  logic [2:0] trig_sel;
  logic [4:0] chan_sel;
  logic [MAP_N-1:0] map_bits;
  logic [7:0] pump_bits;
  logic [RES_W-1:0] low_lim;
  logic [RES_W-1:0] high_lim;
  logic [IRQ_N-1:0] irq_en;
  logic next_enable;
  logic next_diff_mode;
  logic [2:0] next_trig_sel;
  logic [4:0] next_chan_sel;
  logic [MAP_N-1:0] next_map_bits;
  logic [7:0] next_pump_bits;
  logic [RES_W-1:0] next_low_lim;
  logic [RES_W-1:0] next_high_lim;
  logic [IRQ_N-1:0] next_irq_en;
  logic [DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_commit;
  logic sw_start;
  logic [IRQ_N-1:0] irq_clr;
  logic [IRQ_N-1:0] irq_stat;
  logic [RES_W-1:0] result;
  logic busy;

  always_comb begin
    next_enable = enable;
    next_diff_mode = diff_mode;
    next_trig_sel = trig_sel;
    next_chan_sel = chan_sel;
    next_map_bits = map_bits;
    next_pump_bits = pump_bits;
    next_low_lim = low_lim;
    next_high_lim = high_lim;
    next_irq_en = irq_en;
    next_prdata = prdata_o;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    sw_start = 1'b0;
    irq_clr = '0;
    wr_commit = psel_i && penable_i && pready_o && pwrite_i;
    // The answer comes one cycle into the access phase; read data is
    // prepared in that cycle so it is stable when pready is seen.
    if (psel_i && penable_i && !pready_o) begin
      next_pready = 1'b1;
      next_prdata = '0;
      if (paddr_i == OFF_CTRL) begin
        next_prdata[CTRL_START_BIT] = busy;
        next_prdata[CTRL_ENABLE_BIT] = enable;
        next_prdata[CTRL_TRIG_LSB +: 3] = trig_sel;
        next_prdata[CTRL_DIFF_BIT] = diff_mode;
        next_prdata[CTRL_CHAN_LSB +: 5] = chan_sel;
      end else if (paddr_i == OFF_MAP) begin
        next_prdata[MAP_N-1:0] = map_bits;
      end else if (paddr_i == OFF_PUMP) begin
        next_prdata[7:0] = pump_bits;
      end else if (paddr_i == OFF_LOW) begin
        next_prdata[RES_W-1:0] = low_lim;
      end else if (paddr_i == OFF_HIGH) begin
        next_prdata[RES_W-1:0] = high_lim;
      end else if (paddr_i == OFF_RESULT) begin
        next_prdata[RES_W-1:0] = result;
        next_prdata[RESULT_BUSY_BIT] = busy;
      end else if (paddr_i == OFF_STATUS) begin
        next_prdata[IRQ_N-1:0] = irq_stat;
      end else if (paddr_i == OFF_IRQ_EN) begin
        next_prdata[IRQ_N-1:0] = irq_en;
      end else if (paddr_i == OFF_IRQ_CLR) begin
        next_prdata = '0;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    // Writes take effect only at the edge that completes the transfer.
    if (wr_commit) begin
      if (paddr_i == OFF_CTRL) begin
        next_enable = pwdata_i[CTRL_ENABLE_BIT];
        next_trig_sel = pwdata_i[CTRL_TRIG_LSB +: 3];
        next_diff_mode = pwdata_i[CTRL_DIFF_BIT];
        next_chan_sel = pwdata_i[CTRL_CHAN_LSB +: 5];
        sw_start = pwdata_i[CTRL_START_BIT] &&
                   (pwdata_i[CTRL_TRIG_LSB +: 3] == TRIG_SOFTWARE);
      end else if (paddr_i == OFF_MAP) begin
        next_map_bits = pwdata_i[MAP_N-1:0];
      end else if (paddr_i == OFF_PUMP) begin
        next_pump_bits = pwdata_i[7:0];
      end else if (paddr_i == OFF_LOW) begin
        next_low_lim = pwdata_i[RES_W-1:0];
      end else if (paddr_i == OFF_HIGH) begin
        next_high_lim = pwdata_i[RES_W-1:0];
      end else if (paddr_i == OFF_IRQ_EN) begin
        next_irq_en = pwdata_i[IRQ_N-1:0];
      end else if (paddr_i == OFF_IRQ_CLR) begin
        irq_clr = pwdata_i[IRQ_N-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable <= 1'b0;
      diff_mode <= 1'b0;
      trig_sel <= RST_TRIG;
      chan_sel <= RST_CHAN;
      map_bits <= RST_MAP;
      pump_bits <= RST_PUMP;
      low_lim <= RST_LOW;
      high_lim <= RST_HIGH;
      irq_en <= '0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      enable <= next_enable;
      diff_mode <= next_diff_mode;
      trig_sel <= next_trig_sel;
      chan_sel <= next_chan_sel;
      map_bits <= next_map_bits;
      pump_bits <= next_pump_bits;
      low_lim <= next_low_lim;
      high_lim <= next_high_lim;
      irq_en <= next_irq_en;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection and successive-approximation sequencer.

  logic trigger;
  adcts_state_e state;
  adcts_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] next_trial;
  logic [RES_W-1:0] next_result;
  logic done;
  logic next_done;

  always_comb begin
    // The field written together with the start bit already picks the source.
    case (next_trig_sel)
      3'h0: trigger = sw_start;
      3'h1: trigger = cmp_rise[0];
      3'h2: trigger = cmp_rise[1];
      3'h3: trigger = cmp_rise[2];
      3'h4: trigger = cmp_rise[3];
      3'h5: trigger = cmp_rise[4];
      3'h6: trigger = cmp_rise[5];
      default: trigger = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bit_idx = bit_idx;
    next_trial = trial;
    next_result = result;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        // Triggers that arrive while a conversion runs are dropped.
        if (enable && trigger) begin
          next_state = ST_SAMPLE;
          next_cnt = '0;
        end
      end
      ST_SAMPLE: begin
        if (cnt == CNT_W'(SAMPLE_CYC - 1)) begin
          next_state = ST_CONVERT;
          next_cnt = '0;
          next_bit_idx = 4'(RES_W - 1);
          next_trial = 12'h800;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_CONVERT: begin
        if (cnt == CNT_W'(BIT_CYC - 1)) begin
          next_cnt = '0;
          if (!comp_sync) begin
            next_trial[bit_idx] = 1'b0;
          end
          if (bit_idx == 4'h0) begin
            next_state = ST_IDLE;
            next_result = {next_trial[RES_W-1:1], comp_sync};
            next_done = 1'b1;
          end else begin
            next_bit_idx = bit_idx - 1'b1;
            next_trial[bit_idx - 1'b1] = 1'b1;
          end
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!enable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      bit_idx <= 4'h0;
      trial <= '0;
      result <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_idx <= next_bit_idx;
      trial <= next_trial;
      result <= next_result;
      done <= next_done;
    end
  end

  assign busy = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Window comparator and interrupt status.

  logic win_above;
  logic win_below;
  logic win_inside;
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] next_irq_stat;
  logic next_irq;

  adcts_window u_window (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .valid_i(done),
    .result_i(result),
    .low_i(low_lim),
    .high_i(high_lim),
    .above_o(win_above),
    .below_o(win_below),
    .inside_o(win_inside)
  );

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_ABOVE_BIT] = win_above;
    irq_set[IRQ_BELOW_BIT] = win_below;
    irq_set[IRQ_INSIDE_BIT] = win_inside;
    irq_set[IRQ_DONE_BIT] = done;
    // A flag set in the same cycle as its clear stays set.
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-facing outputs.

  logic next_sample;
  logic next_pump_off;
  logic [MAP_N-1:0] next_pin_switch;

  always_comb begin
    next_sample = (next_state == ST_SAMPLE);
    next_pump_off = pump_bits[0] && (next_state != ST_IDLE);
    next_pin_switch = ~next_map_bits;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dac_code_o <= '0;
      sample_o <= 1'b0;
      ref_en_o <= 1'b0;
      diff_mode_o <= 1'b0;
      chan_sel_o <= RST_CHAN;
      pin_switch_o <= ~RST_MAP;
      batt_route_o <= 1'b0;
      temp_route_o <= 1'b0;
      pump_off_o <= 1'b0;
    end else begin
      dac_code_o <= next_trial;
      sample_o <= next_sample;
      ref_en_o <= next_enable;
      diff_mode_o <= next_diff_mode;
      chan_sel_o <= next_chan_sel;
      pin_switch_o <= next_pin_switch;
      batt_route_o <= next_map_bits[MAP_BATT_BIT];
      temp_route_o <= next_map_bits[MAP_TEMP_BIT];
      pump_off_o <= next_pump_off;
    end
  end
endmodule
`default_nettype wire

// ### verification/adcts_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcts_far_model (
  input wire logic clk_i,
  input wire logic [adcts_pkg::RES_W-1:0] level_i,
  input wire logic [adcts_pkg::RES_W-1:0] dac_code_i,
  input wire logic [adcts_pkg::TRIG_N-1:0] fire_i,
  output logic comp_o,
  output logic [adcts_pkg::TRIG_N-1:0] timer_cmp_o
);
  // Ideal analog comparator: high while the input is at or above the trial code.
  assign comp_o = (level_i >= dac_code_i);
  always_ff @(posedge clk_i) begin
    timer_cmp_o <= fire_i;
  end
endmodule
`default_nettype wire

// ### verification/adcts_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcts_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [adcts_pkg::RES_W-1:0] dac_code_o,
  input wire logic sample_o,
  input wire logic [adcts_pkg::MAP_N-1:0] pin_switch_o,
  input wire logic batt_route_o,
  input wire logic temp_route_o,
  input wire logic pump_off_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence samp_s;
    sample_o [*4] ##1 !sample_o;
  endsequence
  sequence busy_s;
    pump_off_o [*8] ##44 pump_off_o ##1 !pump_off_o;
  endsequence
  samp_len_a: assert property ($rose(sample_o) |-> samp_s)
    else $error("sample phase length wrong");
  first_trial_a: assert property ($fell(sample_o) |-> dac_code_o == 12'h800)
    else $error("first trial code wrong");
  pump_cause_a: assert property ($rose(pump_off_o) |-> $rose(sample_o))
    else $error("pump off without conversion start");
  pump_span_a: assert property ($rose(pump_off_o) |-> busy_s)
    else $error("pump off span wrong");
  map_route_a: assert property (batt_route_o != pin_switch_o[5] && temp_route_o != pin_switch_o[4])
    else $error("route and pin switch disagree");
  busy_gap_a: assert property ($fell(sample_o) |-> !sample_o [*8])
    else $error("sampling restarted while busy");
  err_pair_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  irq_hold_a: assert property (irq_o && !psel_i && !$past(psel_i) |=> irq_o)
    else $error("interrupt dropped without a write");
endmodule
bind adcts_top adcts_checker chk_u (.clk_i, .rst_n_i, .psel_i, .pready_o, .pslverr_o, .dac_code_o,
  .sample_o, .pin_switch_o, .batt_route_o, .temp_route_o, .pump_off_o, .irq_o);
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcts_pkg::*;
  localparam int LO = 'h400;
  localparam int HI = 'hC00;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] r;
  logic [31:0] seed = 32'h0000002C;
  logic [TRIG_N-1:0] fire = '0;
  logic [TRIG_N-1:0] tcmp;
  logic [RES_W-1:0] level = '0;
  logic [RES_W-1:0] dac;
  logic [RES_W-1:0] tbl [8] = '{12'h3FF, 12'h400, 12'hC00, 12'hC01, 12'h000, 12'hFFF, 12'h000,
    12'h000};
  logic [MAP_N-1:0] pins;
  logic [MAP_N-1:0] m;
  logic [4:0] chan;
  logic [3:0] en;
  logic [3:0] st;
  logic pready, pslverr, err, comp, sample, ref_en, diff, batt, temp, pump_off, irq;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int lv;
  int res = 0;
  always #2.5 clk_i = ~clk_i;
  adcts_top dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .timer_cmp_i(tcmp), .comp_i(comp), .dac_code_o(dac),
    .sample_o(sample), .ref_en_o(ref_en), .diff_mode_o(diff), .chan_sel_o(chan),
    .pin_switch_o(pins), .batt_route_o(batt), .temp_route_o(temp), .pump_off_o(pump_off),
    .irq_o(irq)
  );
  adcts_far_model far_u (
    .clk_i(clk_i), .level_i(level), .dac_code_i(dac), .fire_i(fire), .comp_o(comp),
    .timer_cmp_o(tcmp)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] flags(input int v);
    return {1'b1, v >= LO && v <= HI, v < LO, v > HI};
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [TRIG_N-1:0] p);
    @(posedge clk_i);
    fire <= p;
    @(posedge clk_i);
    fire <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk("pins", 32'h0000003F, pins);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 8'(i * 4), '0);
      chk("reset value", (i == 4) ? 32'h00000FFF : '0, q);
      chk("slverr", 32'(i == 9), err);
    end
    for (int i = 0; i < 4; i++) begin
      m = 6'(rnd());
      apb(1'b1, OFF_MAP, 32'(m));
      repeat (2) @(posedge clk_i);
      chk("pins", 32'(6'(~m)), pins);
      chk("routes", {m[5], m[4]}, {batt, temp});
    end
    apb(1'b1, OFF_LOW, LO);
    apb(1'b1, OFF_HIGH, HI);
    apb(1'b0, OFF_LOW, '0);
    chk("low limit", LO, q);
    apb(1'b1, OFF_STATUS, 32'h0000000F);
    apb(1'b0, OFF_STATUS, '0);
    chk("status ro", '0, q);
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      lv = (c == 6) ? int'(r[11:0]) : int'(tbl[c]);
      level <= 12'(lv);
      en = (c == 3) ? 4'h0 : 4'hF;
      apb(1'b1, OFF_IRQ_EN, 32'(en));
      apb(1'b1, OFF_PUMP, (c % 2) ? 32'h00000001 : 32'h000000FE);
      w = {11'h000, r[20:16], 7'h00, r[8], 3'h0, 3'(c), 1'b1, 1'(c != 0)};
      apb(1'b1, OFF_CTRL, w);
      pulse((c == 0 || c == 7) ? 6'h3F : 6'h3F ^ (6'h01 << (c - 1)));
      chk("no start", '0, sample);
      chk("ctrl outs", {r[20:16], r[8], 1'b1}, {chan, diff, ref_en});
      if (c == 0) begin
        apb(1'b1, OFF_CTRL, w | 32'h00000001);
        repeat (3) @(posedge clk_i);
      end else if (c < 7) begin
        pulse(6'h01 << (c - 1));
      end
      chk("start", 32'(c < 7), sample);
      chk("pump off", 32'(c < 7 && c % 2 == 1), pump_off);
      q = '0;
      while (c < 7 && q[3] !== 1'b1) begin
        apb(1'b0, OFF_STATUS, '0);
      end
      repeat ((c < 7) ? 3 : 60) @(posedge clk_i);
      res = (c < 7) ? lv : res;
      st = (c < 7) ? flags(lv) : 4'h0;
      apb(1'b0, OFF_RESULT, '0);
      chk("result", res, q);
      apb(1'b0, OFF_STATUS, '0);
      chk("status", st, q);
      chk("irq", 32'((st & en) != 4'h0), irq);
      apb(1'b1, OFF_IRQ_CLR, 32'h0000000F);
      apb(1'b0, OFF_STATUS, '0);
      chk("cleared", '0, {q[30:0], irq});
    end
    apb(1'b1, OFF_PUMP, '0);
    apb(1'b1, OFF_CTRL, 32'h00000003);
    repeat (20) @(posedge clk_i);
    apb(1'b0, OFF_RESULT, '0);
    chk("busy", 32'h00000001, q[16]);
    apb(1'b1, OFF_CTRL, '0);
    apb(1'b0, OFF_RESULT, '0);
    chk("abort busy", '0, q[16]);
    apb(1'b0, OFF_STATUS, '0);
    chk("abort status", '0, q);
    end_sim();
  end
endmodule
`default_nettype wire
